// File: spm_port.sv
/*
 * spm_port: seven-bit bidirectional port with analog select, comparator,
 * reference, slave-select, delay-input and charge-output multiplexing.
 * Assumes an APB master on core_clk and pad cells that combine out/oe.
 */
// The register offsets and the APB slave port were decided locally.

`timescale 1ns/1ps
`default_nettype none
module spm_port
(
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    input  wire logic [7:0]           pad_in,
    output spm_pkg::spm_pad_t         pad,
    input  wire spm_pkg::spm_periph_t periph,
    output logic                      serial_slave_select_in,
    output logic                      charge_timer_delay_input,
    output logic      [15:0]          analog_channel_select_bit
);
    import spm_pkg::*;

    logic [7:0]  port_output_latch;
    logic [7:0]  port_direction;
    logic [7:0]  analog_select_low;
    logic [7:0]  analog_select_high;
    logic [7:0]  periph_ctrl;
    logic [7:0]  next_latch;
    logic [7:0]  next_dir;
    logic [7:0]  next_ana_low;
    logic [7:0]  next_ana_high;
    logic [7:0]  next_periph;
    logic [31:0] next_prdata;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic [7:0]  pin_analog;
    logic [7:0]  in_enable;
    logic [7:0]  port_pin_levels;
    logic [7:0]  next_out;
    logic [7:0]  next_oe;
    logic        wr_en;
    logic        rd_en;

    // true when the address names one of the mapped words
    function automatic logic spm_mapped(input logic [11:0] a);
        return (a == SPM_OFF_LEVELS) || (a == SPM_OFF_LATCH) || (a == SPM_OFF_DIR)
            || (a == SPM_OFF_ANA_LOW) || (a == SPM_OFF_ANA_HIGH) || (a == SPM_OFF_PERIPH);
    endfunction

    // zero-wait-state slave; unmapped addresses answer with pslverr
    // reads are decoded in the setup cycle so that prdata can come from a flop
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !spm_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && pstrb[0] && spm_mapped(paddr);
    assign rd_en   = psel && !penable && !pwrite;

    // analog select is a flat 16-bit vector, a set bit means analog
    assign analog_channel_select_bit = {analog_select_high, analog_select_low};

    // per-pin analog flag from its converter channel
    generate
        genvar gi;
        assign pin_analog[0] = 1'b0;
        for (gi = 1; gi <= 7; gi++)
        begin : g_pin
            assign pin_analog[gi] = analog_channel_select_bit[SPM_CHAN[gi]];
        end
    endgenerate

    // two-flop synchroniser on the pad inputs
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end
        else
        begin
            pin_meta <= pad_in;
            pin_sync <= pin_meta;
        end
    end

    // digital input buffer enabled only on digital inputs, reference pin excluded while the reference is enabled
    always_comb
    begin
        in_enable = port_direction & ~pin_analog & SPM_PIN_MASK;
        if (periph_ctrl[SPM_PC_VREF_EN])
            in_enable[SPM_PIN_VREF] = 1'b0;
        port_pin_levels = pin_sync & in_enable;
    end

    // alternate inputs: slave select ignores the direction bit but is gated by analog select, direction set by software
    assign serial_slave_select_in   = pin_sync[SPM_PIN_SSEL] & ~pin_analog[SPM_PIN_SSEL];
    assign charge_timer_delay_input = pin_sync[SPM_PIN_DELAY] & in_enable[SPM_PIN_DELAY];

    // pad drive: latch unless a peripheral takes over; analog select does not gate it
    always_comb
    begin
        next_oe  = ~port_direction & SPM_PIN_MASK;
        next_out = port_output_latch & SPM_PIN_MASK;
        if (periph_ctrl[SPM_PC_CMP2_EN] && !port_direction[SPM_PIN_CMP2])
            next_out[SPM_PIN_CMP2] = periph.cmp_two_out;
        if (periph_ctrl[SPM_PC_CMP1_EN] && !port_direction[SPM_PIN_CMP1])
            next_out[SPM_PIN_CMP1] = periph.cmp_one_out;
        if (periph_ctrl[SPM_PC_CHRG_EN])
        begin
            next_oe[SPM_PIN_CHRG]  = 1'b1;
            next_out[SPM_PIN_CHRG] = periph.charge_drive;
        end
        if (periph_ctrl[SPM_PC_VREF_EN])
        begin
            next_oe[SPM_PIN_VREF]  = 1'b0;
            next_out[SPM_PIN_VREF] = 1'b0;
        end
    end

    // pad drive is registered so glitches from the mux never reach the pins
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pad.out <= 8'h00;
            pad.oe  <= 8'h00;
        end
        else
        begin
            pad.out <= next_out;
            pad.oe  <= next_oe;
        end
    end

    // register write decode; writes to the level word land in the latch
    always_comb
    begin
        next_latch    = port_output_latch;
        next_dir      = port_direction;
        next_ana_low  = analog_select_low;
        next_ana_high = analog_select_high;
        next_periph   = periph_ctrl;
        if (wr_en)
        begin
            case (paddr)
                SPM_OFF_LEVELS:   next_latch    = pwdata[7:0] & SPM_PIN_MASK;
                SPM_OFF_LATCH:    next_latch    = pwdata[7:0] & SPM_PIN_MASK;
                SPM_OFF_DIR:      next_dir      = pwdata[7:0] & SPM_PIN_MASK;
                SPM_OFF_ANA_LOW:  next_ana_low  = pwdata[7:0];
                SPM_OFF_ANA_HIGH: next_ana_high = pwdata[7:0];
                SPM_OFF_PERIPH:   next_periph   = pwdata[7:0];
                default:          next_latch    = port_output_latch;
            endcase
        end
    end

    // read mux; unmapped reads return zero
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (rd_en)
        begin
            case (paddr)
                SPM_OFF_LEVELS:   next_prdata = {24'h000000, port_pin_levels};
                SPM_OFF_LATCH:    next_prdata = {24'h000000, port_output_latch};
                SPM_OFF_DIR:      next_prdata = {24'h000000, port_direction};
                SPM_OFF_ANA_LOW:  next_prdata = {24'h000000, analog_select_low};
                SPM_OFF_ANA_HIGH: next_prdata = {24'h000000, analog_select_high};
                SPM_OFF_PERIPH:   next_prdata = {24'h000000, periph_ctrl};
                default:          next_prdata = 32'h0000_0000;
            endcase
        end
    end
    // read data registered at the end of setup, standing through the access cycle;
    // the price is a pin level one cycle older than the access edge
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else
            prdata <= next_prdata;
    end

    // control registers; reset puts every pin in analog input mode
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            port_output_latch  <= SPM_RST_LATCH;
            port_direction     <= SPM_RST_DIR;
            analog_select_low  <= SPM_RST_ANA;
            analog_select_high <= SPM_RST_ANA;
            periph_ctrl        <= SPM_RST_PERIPH;
        end
        else
        begin
            port_output_latch  <= next_latch;
            port_direction     <= next_dir;
            analog_select_low  <= next_ana_low;
            analog_select_high <= next_ana_high;
            periph_ctrl        <= next_periph;
        end
    end

    // checks
    sequence s_cfg_out2;
        periph_ctrl[SPM_PC_CMP2_EN] && !port_direction[SPM_PIN_CMP2];
    endsequence

    latch_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !port_direction[4] |=> pad.oe[4] && (pad.out[4] == $past(port_output_latch[4])))
        else $error("latch not driven on output pin");
    input_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pin_analog[2] |-> !port_pin_levels[2])
        else $error("analog pin read as digital");
    reset_analog_a: assert property (@(posedge core_clk)
        $past(sys_rst) |-> analog_channel_select_bit == 16'hffff)
        else $error("analog select not set after reset");
    chan_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pin_analog[7] == analog_select_low[5] && pin_analog[1] == analog_select_low[6])
        else $error("channel mapping wrong");
    cmp_override_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_cfg_out2 |=> pad.out[SPM_PIN_CMP2] == $past(periph.cmp_two_out))
        else $error("comparator output not on pin 1");
    vref_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        periph_ctrl[SPM_PC_VREF_EN] |-> !port_pin_levels[SPM_PIN_VREF] ##1 !pad.oe[SPM_PIN_VREF])
        else $error("reference pin still digital");
    charge_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        periph_ctrl[SPM_PC_CHRG_EN] |=> pad.oe[SPM_PIN_CHRG])
        else $error("charge output not driven");
    bit_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !port_direction[0] && !port_output_latch[0] && !pad.oe[0])
        else $error("bit 0 not zero");

    // comparator one override, the mirror of the pin 1 check above
    sequence s_cfg_out1;
        periph_ctrl[SPM_PC_CMP1_EN] && !port_direction[SPM_PIN_CMP1];
    endsequence
    cmp1_override_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_cfg_out1 |=> pad.out[SPM_PIN_CMP1] == $past(periph.cmp_one_out))
        else $error("comparator output not on pin 2");
    cmp_input_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        periph_ctrl[SPM_PC_CMP2_EN] && port_direction[SPM_PIN_CMP2] |=> !pad.oe[SPM_PIN_CMP2])
        else $error("comparator drives pin 1 set as input");
    latch_analog_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !port_direction[SPM_PIN_SSEL] && pin_analog[SPM_PIN_SSEL] |=> pad.oe[SPM_PIN_SSEL]
            && pad.out[SPM_PIN_SSEL] == $past(port_output_latch[SPM_PIN_SSEL]))
        else $error("latch not driven on analog output pin");

    // a pad level reaches the core two edges later, through the synchroniser
    sequence s_ssel_pad_high;
        pad_in[SPM_PIN_SSEL] ##2 !pin_analog[SPM_PIN_SSEL];
    endsequence
    slave_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_ssel_pad_high |-> serial_slave_select_in)
        else $error("slave select does not follow pin 7");
    slave_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pin_analog[SPM_PIN_SSEL] |-> !serial_slave_select_in)
        else $error("slave select active on analog pin");
    sequence s_delay_pad_high;
        pad_in[SPM_PIN_DELAY] ##2 in_enable[SPM_PIN_DELAY];
    endsequence
    delay_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_delay_pad_high |-> charge_timer_delay_input)
        else $error("delay input does not follow pin 1");
    delay_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !in_enable[SPM_PIN_DELAY] |-> !charge_timer_delay_input)
        else $error("delay input active while pin 1 not an input");

    // the charge output ignores the direction bit entirely
    charge_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        periph_ctrl[SPM_PC_CHRG_EN] && port_direction[SPM_PIN_CHRG]
        |=> pad.oe[SPM_PIN_CHRG] && pad.out[SPM_PIN_CHRG] == $past(periph.charge_drive))
        else $error("charge output not driven over input direction");

    // a software write to the low analog word shows up on the select vector
    sequence s_ana_low_write;
        wr_en && (paddr == SPM_OFF_ANA_LOW);
    endsequence
    ana_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_ana_low_write |=> analog_channel_select_bit[7:0] == $past(pwdata[7:0]))
        else $error("analog select write lost");
    level_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (port_pin_levels & (pin_analog | ~SPM_PIN_MASK)) == 8'h00)
        else $error("analog pin or bit 0 read as set");
    reset_levels_a: assert property (@(posedge core_clk)
        $past(sys_rst) |-> port_pin_levels == 8'h00 && pad.oe == 8'h00)
        else $error("pins not quiet after reset");
endmodule
`default_nettype wire

// File: spm_pkg.sv
/*
 * spm_pkg: shared constants and types for the seven-bit port pin mux.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`default_nettype none
package spm_pkg;
    // register byte offsets
    localparam logic [11:0] SPM_OFF_LEVELS   = 12'h000;
    localparam logic [11:0] SPM_OFF_LATCH    = 12'h004;
    localparam logic [11:0] SPM_OFF_DIR      = 12'h008;
    localparam logic [11:0] SPM_OFF_ANA_LOW  = 12'h00c;
    localparam logic [11:0] SPM_OFF_ANA_HIGH = 12'h010;
    localparam logic [11:0] SPM_OFF_PERIPH   = 12'h014;
    // reset values
    localparam logic [7:0] SPM_RST_LATCH = 8'h00;
    localparam logic [7:0] SPM_RST_DIR   = 8'hfe;
    localparam logic [7:0] SPM_RST_ANA   = 8'hff;
    localparam logic [7:0] SPM_RST_PERIPH = 8'h00;
    // bit 0 of the port registers is not implemented
    localparam logic [7:0] SPM_PIN_MASK = 8'hfe;
    // peripheral-control register field positions
    localparam int SPM_PC_CMP2_EN  = 0;
    localparam int SPM_PC_CMP1_EN  = 1;
    localparam int SPM_PC_VREF_EN  = 2;
    localparam int SPM_PC_CHRG_EN  = 3;
    // pin positions of the special functions
    localparam int SPM_PIN_CMP2  = 1;
    localparam int SPM_PIN_CMP1  = 2;
    localparam int SPM_PIN_CHRG  = 3;
    localparam int SPM_PIN_VREF  = 5;
    localparam int SPM_PIN_SSEL  = 7;
    localparam int SPM_PIN_DELAY = 1;
    // analog channel of each pin 1..7 (index by pin)
    localparam int SPM_CHAN [1:7] = '{6, 7, 8, 9, 10, 11, 5};

    // pin drive bundle towards the pads
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } spm_pad_t;

    // on-chip peripheral requests
    typedef struct packed {
        logic cmp_two_out;
        logic cmp_one_out;
        logic charge_drive;
    } spm_periph_t;
endpackage
`default_nettype wire

// File: spm_board.sv
/*
 * spm_board: board circuitry on the seven port pins.
 * Assumes pull-ups on every pin and a bench that sets external drivers.
 */
`timescale 1ns/1ps
`default_nettype none
module spm_board
(
    input  wire spm_pkg::spm_pad_t pad,
    input  wire logic [7:0]        ext_val,
    input  wire logic [7:0]        ext_en,
    output logic      [7:0]        pad_in
);
    import spm_pkg::*;
    // device drive wins, then an enabled external driver; a pin neither drives floats up to its pull-up level
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pad_in[i] = pad.oe[i] ? pad.out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
/*
 * tb: self-checking bench for spm_port through its APB slave and pads.
 * Assumes zero-wait-state APB and registered pad drive.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spm_pkg::*;
    logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
    logic        ss_in, dly_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  pad_in, ext_val, ext_en;
    logic [15:0] ana;
    spm_pad_t    pad;
    spm_periph_t periph;
    int          bad_count, n_compared;
    spm_port spm_port_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pad_in(pad_in), .pad(pad), .periph(periph), .serial_slave_select_in(ss_in),
        .charge_timer_delay_input(dly_in), .analog_channel_select_bit(ana));
    spm_board spm_board_i (.pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
    // clock generator
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            chk(32'h1, 32'h0);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    // settle a few edges so pad drive and the input synchroniser catch up
    task automatic settle();
        repeat (3) @(posedge core_clk);
    endtask
    task automatic t_reset();
        rdc(SPM_OFF_LATCH, 8'h00);
        rdc(SPM_OFF_DIR, 8'hfe);
        rdc(SPM_OFF_ANA_LOW, 8'hff);
        rdc(SPM_OFF_ANA_HIGH, 8'hff);
        rdc(SPM_OFF_LEVELS, 8'h00);
        chk({16'h0, ana}, 32'hffff);
        chk({16'h0, pad.oe}, 32'h0);
        apb(1'b0, 12'h018, 8'h00);
        chk({31'h0, er}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_out();
        apb(1'b1, SPM_OFF_ANA_LOW, 8'h00);
        apb(1'b1, SPM_OFF_ANA_HIGH, 8'h00);
        apb(1'b1, SPM_OFF_DIR, 8'h01);
        apb(1'b1, SPM_OFF_LATCH, 8'hab);
        settle();
        chk({16'h0, pad}, {16'h0, 8'haa, 8'hfe});
        rdc(SPM_OFF_LATCH, 8'haa);
        rdc(SPM_OFF_DIR, 8'h00);
        apb(1'b1, SPM_OFF_LEVELS, 8'h55);
        rdc(SPM_OFF_LATCH, 8'h54);
        apb(1'b1, SPM_OFF_ANA_LOW, 8'hff);
        apb(1'b1, SPM_OFF_ANA_HIGH, 8'hff);
        settle();
        chk({24'h0, pad.oe}, 32'hfe);
        $display("test output done");
    endtask
    task automatic t_in();
        int chan [1:7] = '{6, 7, 8, 9, 10, 11, 5};
        logic [15:0] sel;
        apb(1'b1, SPM_OFF_DIR, 8'hfe);
        for (int p = 1; p <= 7; p++)
        begin
            sel = 16'h1 << chan[p];
            apb(1'b1, SPM_OFF_ANA_LOW, sel[7:0]);
            apb(1'b1, SPM_OFF_ANA_HIGH, sel[15:8]);
            settle();
            rdc(SPM_OFF_LEVELS, 8'hfe & ~(8'h1 << p));
            chk({16'h0, ana}, {16'h0, sel});
        end
        // pin 7 is still analog from the last pass, so slave select stays low
        chk({31'h0, ss_in}, 32'h0);
        apb(1'b1, SPM_OFF_ANA_LOW, 8'h00);
        ext_en <= 8'hff;
        ext_val <= 8'h5b;
        settle();
        rdc(SPM_OFF_LEVELS, 8'h5a);
        chk({30'h0, ss_in, dly_in}, 32'h1);
        ext_val <= 8'h80;
        settle();
        chk({30'h0, ss_in, dly_in}, 32'h2);
        $display("test input done");
    endtask
    task automatic t_periph();
        ext_val <= 8'hff;
        periph <= '{cmp_two_out: 1'b1, cmp_one_out: 1'b1, charge_drive: 1'b1};
        apb(1'b1, SPM_OFF_LATCH, 8'h00);
        apb(1'b1, SPM_OFF_DIR, 8'h00);
        apb(1'b1, SPM_OFF_PERIPH, 8'h0f);
        settle();
        chk({24'h0, pad.out & 8'h06}, 32'h6);
        chk({31'h0, pad.oe[5]}, 32'h0);
        apb(1'b1, SPM_OFF_DIR, 8'hfe);
        settle();
        chk({16'h0, pad}, {16'h0, 8'h08, 8'h08});
        rdc(SPM_OFF_LEVELS, 8'hde);
        $display("test peripherals done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog: the whole run needs well under 1000 cycles
    initial
    begin
        #100us;
        bad_count++;
        summarize();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_val, ext_en, periph, bad_count, n_compared} = '0;
        sys_rst = 1'b1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_out();
        t_in();
        t_periph();
        summarize();
    end
endmodule
`default_nettype wire
